// *** design/reset_cause_defs.svh ***
// Register offsets, bit positions, reset values and timing counts of the reset cause controller
`ifndef RESET_CAUSE_DEFS_SVH
`define RESET_CAUSE_DEFS_SVH
`define CAUSE_REG_OFFSET     12'h000
`define IRQ_STATUS_OFFSET    12'h004
`define IRQ_MASK_OFFSET      12'h008
`define CTRL_OFFSET          12'h00C
`define STATUS_OFFSET        12'h010
`define BIT_TRAP_CLASH       15
`define BIT_ILLEGAL_ACCESS   14
`define BIT_PINSEL_MISMATCH  9
`define BIT_EXT_PIN          7
`define BIT_SOFT_RESET       6
`define BIT_WDOG_EXPIRY      4
`define BIT_BROWNOUT         1
`define BIT_POWERON          0
`define CAUSE_WRITE_MASK     16'hC2D3
`define CAUSE_RESET_VALUE    16'h0001
`define IRQ_RESET_VALUE      16'h0000
`define HARD_TRAP_MIN        4'hD
`define HARD_TRAP_MAX        4'hF
`define ILLEGAL_UPPER_BYTE   8'h3F
`define RESET_VECTOR         24'h000000
`define SYSTEM_RESET_LINE_CYCLES        2'h1
`endif

// *** design/reset_cause_pkg.sv ***
// Types shared by the reset cause controller
package reset_cause_pkg;
   typedef struct packed {
      logic       valid;
      logic [3:0] level;
   } trap_event_type;
   typedef struct packed {
      logic        valid;
      logic [7:0]  upper_byte;
      logic        uninit_ptr;
   } fetch_event_type;
   typedef struct packed {
      logic        program_flow_change;
      logic        vector_flow_change;
      logic        target_restricted;
   } flow_event_type;
   typedef enum logic [1:0] {
      RUN,
      HOLD,
      RELEASE
   } seq_state_type;
endpackage

// *** design/reset_cause_controller.sv ***
// Reset source collection, reset cause register and AXI4-Lite register slave
// How it works
// - Software reset instruction asserts system reset but keeps current clock selection.
// - After software reset, system reset releases next cycle, then reset vector fetch.
// - Software reset sets the soft reset flag, bit 6.
// - Running watchdog expiry asynchronously asserts system reset, clock unchanged; here it is registered and asserts reset at the next clock edge.
// - Watchdog expiry in sleep or idle only wakes the core, no reset.
// - Watchdog expiry sets watchdog expiry flag, bit 4; here only expiry while running sets it, not expiry in sleep or idle.
// - Lower hard trap during higher trap service (levels 13-15) resets the device.
// - Trap conflict reset sets trap clash flag, bit 15.
// - Pin-select registers compared with shadows; mismatch resets and sets bit 9.
// - Illegal opcode, upper byte 3Fh included, resets and sets bit 14.
// - Resets clear working registers except stack pointer; uninitialized pointer use resets.
// - Flow change into restricted protected segment location causes a security reset.
// - Call, jump, return, branch are program flow; vector loads are vector flow.
// - Illegal sources share bit 14; flags clear on cold reset, pin flag on power-on.
// - Watchdog flag cleared by power-save, watchdog clear, power-on or brown-out.
// - Software can set or clear every cause flag directly.
// - Any reset clears registers and forces program counter to zero.
// - Master clear pin low gives external reset and sets external pin flag.
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`include "reset_cause_defs.svh"
module reset_cause_controller
   import reset_cause_pkg::*;
#(
   parameter int PINSEL_WIDTH = 16
)(
   // Clock and reset
   input  wire logic                    ref_clk_in,
   input  wire logic                    resetn_in,
   // Cold reset sources and the master clear pin
   input  wire logic                    poweron_reset_in,
   input  wire logic                    brownout_reset_in,
   input  wire logic                    master_clear_pin_n_in,
   // Core events
   input  wire logic                    reset_instruction_in,
   input  wire logic                    power_save_instruction_in,
   input  wire logic                    watchdog_clear_instruction_in,
   input  wire logic                    power_saving_in,
   input  wire logic                    watchdog_expiry_in,
   input  wire trap_event_type          trap_in,
   input  wire logic [3:0]              trap_serviced_level_in,
   input  wire logic                    trap_in_service_in,
   input  wire fetch_event_type         fetch_in,
   input  wire flow_event_type          flow_in,
   input  wire logic [PINSEL_WIDTH-1:0] pinsel_regs_in,
   input  wire logic [PINSEL_WIDTH-1:0] pinsel_shadow_in,
   // Reset outputs to the core
   output logic                         system_reset_line_out,
   output logic                         keep_clock_source_out,
   output logic                         clear_working_regs_out,
   output logic [23:0]                  program_counter_load_out,
   output logic                         wake_out,
   output logic                         irq_out,
   // AXI4-Lite slave
   input  wire logic [11:0]             s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic [1:0]                   s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   input  wire logic [11:0]             s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic [31:0]                  s_axi_rdata,
   output logic [1:0]                   s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready
);

   function automatic logic [15:0] bit_of(input int pos);
      bit_of = 16'h0001 << pos;
   endfunction

   function automatic logic [15:0] lane_merge(input logic [15:0] old_v, input logic [31:0] d, input logic [3:0] s);
      lane_merge = {s[1] ? d[15:8] : old_v[15:8], s[0] ? d[7:0] : old_v[7:0]};
   endfunction

   logic [15:0]   cause;
   logic [15:0]   irq_status;
   logic [15:0]   irq_mask;
   logic          pinsel_check_en;
   seq_state_type state;
   seq_state_type next_state;
   logic [15:0]   last_cause;

   // Event decoding
   wire cold_reset      = poweron_reset_in | brownout_reset_in;
   wire ext_event       = ~master_clear_pin_n_in;
   wire soft_event      = reset_instruction_in;
   wire wdog_reset      = watchdog_expiry_in & ~power_saving_in;
   wire wdog_wake       = watchdog_expiry_in & power_saving_in;
   wire hard_new        = trap_in.valid && trap_in.level >= `HARD_TRAP_MIN;
   wire trap_event      = hard_new && trap_in_service_in &&
                          trap_serviced_level_in > trap_in.level;
   wire mismatch_event  = pinsel_check_en && (pinsel_regs_in != pinsel_shadow_in);
   wire opcode_event    = fetch_in.valid && fetch_in.upper_byte == `ILLEGAL_UPPER_BYTE;
   wire uninit_event    = fetch_in.valid && fetch_in.uninit_ptr;
   wire any_flow        = flow_in.program_flow_change | flow_in.vector_flow_change;
   wire security_event  = any_flow && flow_in.target_restricted;
   wire illegal_event   = opcode_event | uninit_event | security_event;
   wire sync_reset_req  = soft_event | trap_event | mismatch_event | illegal_event | ext_event;

   wire [15:0] hw_set = (trap_event     ? bit_of(`BIT_TRAP_CLASH)      : 16'h0000) |
                        (illegal_event  ? bit_of(`BIT_ILLEGAL_ACCESS)  : 16'h0000) |
                        (mismatch_event ? bit_of(`BIT_PINSEL_MISMATCH) : 16'h0000) |
                        (ext_event      ? bit_of(`BIT_EXT_PIN)         : 16'h0000) |
                        (soft_event     ? bit_of(`BIT_SOFT_RESET)      : 16'h0000) |
                        (wdog_reset     ? bit_of(`BIT_WDOG_EXPIRY)     : 16'h0000) |
                        (brownout_reset_in ? bit_of(`BIT_BROWNOUT)     : 16'h0000) |
                        (poweron_reset_in  ? bit_of(`BIT_POWERON) | bit_of(`BIT_BROWNOUT) : 16'h0000);

   // Cold reset clears everything but its own flags; only power-on clears the pin flag
   wire [15:0] hw_clear = (cold_reset ? (`CAUSE_WRITE_MASK & ~bit_of(`BIT_EXT_PIN) &
                           ~bit_of(`BIT_BROWNOUT) & ~bit_of(`BIT_POWERON)) : 16'h0000) |
                          (poweron_reset_in ? bit_of(`BIT_EXT_PIN) : 16'h0000) |
                          ((power_save_instruction_in | watchdog_clear_instruction_in)
                           ? bit_of(`BIT_WDOG_EXPIRY) : 16'h0000);

   // AXI4-Lite write path: address and data held until both present
   logic        aw_held;
   logic        w_held;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   wire aw_take   = s_axi_awvalid & s_axi_awready;
   wire w_take    = s_axi_wvalid & s_axi_wready;
   wire do_write  = aw_held & w_held & ~s_axi_bvalid;
   wire wr_cause  = do_write && aw_addr == `CAUSE_REG_OFFSET;
   wire wr_istat  = do_write && aw_addr == `IRQ_STATUS_OFFSET;
   wire wr_imask  = do_write && aw_addr == `IRQ_MASK_OFFSET;
   wire wr_ctrl   = do_write && aw_addr == `CTRL_OFFSET;
   wire wr_known  = wr_cause | wr_istat | wr_imask | wr_ctrl || aw_addr == `STATUS_OFFSET;

   // Software write comes first, hardware events then override it
   wire [15:0] sw_cause   = wr_cause ? lane_merge(cause, w_data, w_strb) & `CAUSE_WRITE_MASK
                                     : cause;
   wire [15:0] next_cause = (sw_cause & ~hw_clear) | hw_set;
   wire [15:0] w1c        = wr_istat ? lane_merge(16'h0000, w_data, w_strb) : 16'h0000;
   wire [15:0] next_istat = (irq_status & ~w1c) | hw_set;

   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         cause      <= `CAUSE_RESET_VALUE;
         irq_status <= `IRQ_RESET_VALUE;
         irq_mask   <= `IRQ_RESET_VALUE;
         pinsel_check_en <= 1'b1;
      end
      else
      begin
         cause      <= next_cause;
         irq_status <= next_istat;
         if (wr_imask)
            irq_mask <= lane_merge(irq_mask, w_data, w_strb);
         if (wr_ctrl && w_strb[0])
            pinsel_check_en <= w_data[0];
      end
   end

   // Reset sequencer: synchronous sources hold reset one cycle, the master clear pin as long as it is low, then release
   always_comb
   begin
      next_state = state;
      case (state)
         RUN:     next_state = (sync_reset_req || cold_reset) ? HOLD : RUN;
         HOLD:    next_state = (cold_reset || ext_event) ? HOLD : RELEASE;
         RELEASE: next_state = sync_reset_req ? HOLD : RUN;
         default: next_state = RUN;
      endcase
   end

   logic wdog_hold;
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         state      <= RUN;
         wdog_hold  <= 1'b0;
         last_cause <= 16'h0000;
      end
      else
      begin
         state      <= next_state;
         wdog_hold  <= wdog_reset;
         last_cause <= cause;
      end
   end

   // Watchdog reaches the reset line through the register, at the next clock edge
   wire reset_level = (state == HOLD) | wdog_hold;
   logic system_reset_line_q;
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         system_reset_line_q <= 1'b1;
      else
         system_reset_line_q <= (next_state == HOLD) | wdog_reset;
   end
   assign system_reset_line_out = system_reset_line_q;

   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         keep_clock_source_out    <= 1'b0;
         clear_working_regs_out   <= 1'b1;
         program_counter_load_out <= `RESET_VECTOR;
         wake_out                 <= 1'b0;
         irq_out                  <= 1'b0;
      end
      else
      begin
         keep_clock_source_out    <= ~cold_reset;
         clear_working_regs_out   <= (next_state == HOLD) | wdog_reset;
         program_counter_load_out <= `RESET_VECTOR;
         wake_out                 <= wdog_wake;
         irq_out                  <= |(next_istat & irq_mask);
      end
   end

   // AXI4-Lite handshakes: one write and one read at a time
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 12'h000;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end
      else
      begin
         if (aw_take)
         begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[11:2], 2'h0};
            s_axi_awready <= 1'b0;
         end
         if (w_take)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? 2'h0 : 2'h2;
            aw_held <= 1'b0;
            w_held  <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   wire [11:0] ra = {s_axi_araddr[11:2], 2'h0};
   wire        r_known = ra == `CAUSE_REG_OFFSET || ra == `IRQ_STATUS_OFFSET ||
                         ra == `IRQ_MASK_OFFSET || ra == `CTRL_OFFSET || ra == `STATUS_OFFSET;
   wire [15:0] r_word  = ra == `CAUSE_REG_OFFSET  ? cause :
                         ra == `IRQ_STATUS_OFFSET ? irq_status :
                         ra == `IRQ_MASK_OFFSET   ? irq_mask :
                         ra == `CTRL_OFFSET       ? {15'h0000, pinsel_check_en} :
                         ra == `STATUS_OFFSET     ? {13'h0000, reset_level, state == HOLD, wake_out} :
                         16'h0000;

   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {16'h0000, r_word};
         s_axi_rresp   <= r_known ? 2'h0 : 2'h2;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Checks
   a_soft_sets_flag: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      soft_event && !cold_reset |=> cause[`BIT_SOFT_RESET]) else $error("soft flag not set");
   a_soft_release: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      soft_event && state == RUN && !cold_reset && !ext_event ##1 !sync_reset_req && !wdog_reset && !cold_reset
      |=> !system_reset_line_out) else $error("reset not released");
   a_soft_asserts: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      soft_event |=> system_reset_line_out && keep_clock_source_out == !$past(cold_reset))
      else $error("soft reset missing");
   a_wdog_reset: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      wdog_reset |=> system_reset_line_out && cause[`BIT_WDOG_EXPIRY]) else $error("watchdog reset missing");
   a_wdog_sleep: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      watchdog_expiry_in && power_saving_in && !sync_reset_req && !cold_reset && state == RUN && !wdog_hold
      |=> wake_out && !system_reset_line_out) else $error("watchdog reset in sleep");
   a_trap_clash: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      trap_in.valid && trap_in.level >= 4'hD && trap_in_service_in && trap_serviced_level_in > trap_in.level
      |=> cause[`BIT_TRAP_CLASH] && system_reset_line_out) else $error("trap clash missed");
   a_illegal_op: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      fetch_in.valid && fetch_in.upper_byte == 8'h3F && !cold_reset
      |=> cause[`BIT_ILLEGAL_ACCESS] && system_reset_line_out) else $error("illegal opcode missed");
   a_mismatch: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      pinsel_check_en && pinsel_regs_in != pinsel_shadow_in && !cold_reset
      |=> cause[`BIT_PINSEL_MISMATCH]) else $error("mismatch missed");
   a_wdog_clear: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      watchdog_clear_instruction_in && !wdog_reset && !wr_cause |=> !cause[`BIT_WDOG_EXPIRY])
      else $error("watchdog flag not cleared");
   // The clear that could explain a lost flag happened one edge ago, so look at the past cold reset
   a_flag_sticky: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
      last_cause[`BIT_TRAP_CLASH] && !$past(cold_reset) && !$past(wr_cause) |-> cause[`BIT_TRAP_CLASH])
      else $error("flag lost");
   c_soft: cover property (@(posedge ref_clk_in) disable iff (!resetn_in) soft_event ##2 state == RUN);
   c_wdog: cover property (@(posedge ref_clk_in) disable iff (!resetn_in) wdog_reset);
   c_security: cover property (@(posedge ref_clk_in) disable iff (!resetn_in) security_event);
   c_write: cover property (@(posedge ref_clk_in) disable iff (!resetn_in) wr_cause);
endmodule

// *** dv/core_model.sv ***
// Behavioural core, watchdog and fault detectors raising reset events on command
`timescale 1ns/100ps
module core_model
   import reset_cause_pkg::*;
#(
   parameter int PINSEL_WIDTH = 16
)(
   // Clock and command from the bench
   input  wire logic                    ref_clk_in,
   input  wire logic                    go_in,
   input  wire logic [3:0]              code_in,
   input  wire logic [7:0]              arg_in,
   // Events toward the controller
   output logic                         reset_instruction_out,
   output logic                         power_save_instruction_out,
   output logic                         watchdog_clear_instruction_out,
   output logic                         power_saving_out,
   output logic                         watchdog_expiry_out,
   output trap_event_type               trap_out,
   output logic [3:0]                   trap_serviced_level_out,
   output logic                         trap_in_service_out,
   output fetch_event_type              fetch_out,
   output flow_event_type               flow_out,
   output logic [PINSEL_WIDTH-1:0]      pinsel_regs_out,
   output logic [PINSEL_WIDTH-1:0]      pinsel_shadow_out
);
   logic [3:0] cur = 4'h0;
   logic [7:0] val = 8'h00;
   // Every event lasts exactly one cycle, as the core would issue it
   always @(posedge ref_clk_in)
   begin
      cur <= go_in ? code_in : 4'h0;
      val <= arg_in;
   end
   assign reset_instruction_out = cur == 4'h1;
   assign watchdog_expiry_out = cur == 4'h2 || cur == 4'hE;
   assign power_saving_out = cur == 4'hE;
   assign power_save_instruction_out = cur == 4'h9;
   assign watchdog_clear_instruction_out = cur == 4'hA;
   // A level 14 trap is always in service; arrivals below, above, or outside the hard range
   assign trap_in_service_out = 1'b1;
   assign trap_serviced_level_out = 4'hE;
   assign trap_out = '{cur == 4'h3 || cur == 4'hB || cur == 4'hF, cur == 4'h3 ? 4'hD : (cur == 4'hB ? 4'hF : 4'hC)};
   assign fetch_out = '{cur == 4'h5 || cur == 4'h6 || cur == 4'hC, cur == 4'h5 ? 8'h3F : val, cur == 4'h6};
   assign flow_out = '{cur == 4'h7 || cur == 4'hD, cur == 4'h8, cur == 4'h7 || cur == 4'h8};
   // Registers move with every command so the shadow compare runs on changing values
   assign pinsel_regs_out = {(PINSEL_WIDTH/8){val}};
   assign pinsel_shadow_out = pinsel_regs_out ^ PINSEL_WIDTH'(cur == 4'h4);
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the reset cause controller driven through a core model
`timescale 1ns/100ps
`include "reset_cause_defs.svh"
module testbench
   import reset_cause_pkg::*;
;
   localparam logic [11:0] CR = `CAUSE_REG_OFFSET;
   logic ref_clk_in = 1'b0, resetn_in = 1'b0, poweron_reset_in = 1'b0, brownout_reset_in = 1'b0;
   logic master_clear_pin_n_in = 1'b1, go = 1'b0;
   logic [3:0] code = 4'h0;
   logic [7:0] arg = 8'h00;
   logic reset_instruction_in, power_save_instruction_in, watchdog_clear_instruction_in, power_saving_in;
   logic watchdog_expiry_in, trap_in_service_in;
   logic [3:0] trap_serviced_level_in;
   trap_event_type trap_in;
   fetch_event_type fetch_in;
   flow_event_type flow_in;
   logic [15:0] pinsel_regs_in, pinsel_shadow_in, mask_now = 16'h0000;
   logic system_reset_line_out, keep_clock_source_out, clear_working_regs_out, wake_out, irq_out;
   logic [23:0] program_counter_load_out;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int n_errors = 0, checked = 0, cycles = 0;

   initial forever #10 ref_clk_in = ~ref_clk_in;

   reset_cause_controller #(.PINSEL_WIDTH(16)) uut (.ref_clk_in, .resetn_in, .poweron_reset_in, .brownout_reset_in,
      .master_clear_pin_n_in, .reset_instruction_in, .power_save_instruction_in, .watchdog_clear_instruction_in,
      .power_saving_in, .watchdog_expiry_in, .trap_in, .trap_serviced_level_in, .trap_in_service_in, .fetch_in,
      .flow_in, .pinsel_regs_in, .pinsel_shadow_in, .system_reset_line_out, .keep_clock_source_out,
      .clear_working_regs_out, .program_counter_load_out, .wake_out, .irq_out, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   core_model #(.PINSEL_WIDTH(16)) core (.ref_clk_in, .go_in(go), .code_in(code), .arg_in(arg),
      .reset_instruction_out(reset_instruction_in), .power_save_instruction_out(power_save_instruction_in),
      .watchdog_clear_instruction_out(watchdog_clear_instruction_in), .power_saving_out(power_saving_in),
      .watchdog_expiry_out(watchdog_expiry_in), .trap_out(trap_in), .trap_serviced_level_out(trap_serviced_level_in),
      .trap_in_service_out(trap_in_service_in), .fetch_out(fetch_in), .flow_out(flow_in),
      .pinsel_regs_out(pinsel_regs_in), .pinsel_shadow_out(pinsel_shadow_in));

   task automatic tally_and_finish();
      if (n_errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // A hang anywhere in a handshake ends here
   always @(posedge ref_clk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         n_errors++;
         $display("CHECK FAILED %0t timeout", $time);
         tally_and_finish();
      end
   end

   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge ref_clk_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge ref_clk_in);
         aw_done = aw_done || s_axi_awready === 1'b1;
         w_done = w_done || s_axi_wready === 1'b1;
         s_axi_awvalid <= !aw_done;
         s_axi_wvalid <= !w_done;
      end
      while (s_axi_bvalid !== 1'b1)
         @(posedge ref_clk_in);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk_in);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
         @(posedge ref_clk_in);
      while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1)
         @(posedge ref_clk_in);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   function automatic logic [15:0] exp_flag(input logic [3:0] c);
      case (c)
         4'h1: return 16'h1 << `BIT_SOFT_RESET;
         4'h2: return 16'h1 << `BIT_WDOG_EXPIRY;
         4'h3: return 16'h1 << `BIT_TRAP_CLASH;
         4'h4: return 16'h1 << `BIT_PINSEL_MISMATCH;
         4'h5, 4'h6, 4'h7, 4'h8: return 16'h1 << `BIT_ILLEGAL_ACCESS;
         default: return 16'h0000;
      endcase
   endfunction

   // Fire one core event after presetting the cause register, then check outputs and flags
   task automatic hit(input logic [3:0] c, input logic [15:0] pre, input logic en);
      logic [15:0] f;
      logic [31:0] d;
      logic [1:0] r;
      f = (c == 4'h4 && !en) ? 16'h0000 : exp_flag(c);
      axi_wr(CR, {16'h0000, pre}, 4'hF, r);
      axi_wr(`IRQ_STATUS_OFFSET, 32'h0000FFFF, 4'hF, r);
      @(posedge ref_clk_in);
      code <= c;
      arg <= 8'($urandom_range(62, 0));
      go <= 1'b1;
      @(posedge ref_clk_in);
      go <= 1'b0;
      @(posedge ref_clk_in);
      #1;
      chk(system_reset_line_out, f != 16'h0);
      chk(clear_working_regs_out, f != 16'h0);
      chk(wake_out, c == 4'hE);
      chk(keep_clock_source_out, 1'b1);
      chk(program_counter_load_out, `RESET_VECTOR);
      @(posedge ref_clk_in);
      #1;
      chk(system_reset_line_out, 1'b0);
      chk(wake_out, 1'b0);
      axi_rd(CR, d, r);
      chk(d, {16'h0000, f});
      chk(irq_out, (f & mask_now) != 16'h0);
   endtask

   initial
   begin
      logic [31:0] d, e;
      logic [1:0] r;
      void'($urandom(48));
      repeat (6) @(posedge ref_clk_in);
      chk(system_reset_line_out, 1'b1);
      resetn_in <= 1'b1;
      axi_rd(CR, d, r);
      chk(d, {16'h0000, `CAUSE_RESET_VALUE});
      axi_rd(`CTRL_OFFSET, d, r);
      chk(d, 32'h00000001);
      axi_rd(`IRQ_MASK_OFFSET, d, r);
      chk(d, 32'h00000000);
      axi_rd(12'h020, d, r);
      chk(d, 32'h0);
      chk(r, 2'h2);
      axi_wr(12'h020, 32'hFFFFFFFF, 4'hF, r);
      chk(r, 2'h2);
      mask_now = 16'hFFFF;
      axi_wr(`IRQ_MASK_OFFSET, 32'h0000FFFF, 4'hF, r);
      for (int c = 1; c < 16; c++)
         hit(4'(c), (c == 9 || c == 10) ? 16'h1 << `BIT_WDOG_EXPIRY : 16'h0000, 1'b1);
      // Shadow compare switched off: a mismatch must pass unnoticed
      axi_wr(`CTRL_OFFSET, 32'h0, 4'hF, r);
      hit(4'h4, 16'h0000, 1'b0);
      axi_wr(`CTRL_OFFSET, 32'h1, 4'hF, r);
      mask_now = 16'h0000;
      axi_wr(`IRQ_MASK_OFFSET, 32'h0, 4'hF, r);
      hit(4'h1, 16'h0000, 1'b1);
      axi_wr(`IRQ_MASK_OFFSET, 32'h00000040, 4'hF, r);
      repeat (2) @(posedge ref_clk_in);
      #1;
      chk(irq_out, 1'b1);
      axi_wr(`IRQ_STATUS_OFFSET, 32'h00000040, 4'hF, r);
      repeat (2) @(posedge ref_clk_in);
      #1;
      chk(irq_out, 1'b0);
      axi_wr(CR, 32'h0, 4'hF, r);
      axi_wr(CR, 32'h0000FFFF, 4'h1, r);
      axi_rd(CR, d, r);
      chk(d, 32'h000000D3);
      repeat (8)
      begin
         d = $urandom;
         axi_wr(CR, d, 4'hF, r);
         axi_rd(CR, e, r);
         chk(e, {16'h0000, d[15:0] & `CAUSE_WRITE_MASK});
      end
      axi_wr(CR, 32'h0000FFFF, 4'hF, r);
      @(posedge ref_clk_in);
      brownout_reset_in <= 1'b1;
      @(posedge ref_clk_in);
      brownout_reset_in <= 1'b0;
      #1;
      chk(system_reset_line_out, 1'b1);
      chk(keep_clock_source_out, 1'b0);
      axi_rd(CR, d, r);
      chk(d, 32'h00000083);
      axi_wr(CR, 32'h0, 4'hF, r);
      @(posedge ref_clk_in);
      master_clear_pin_n_in <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      #1;
      chk(system_reset_line_out, 1'b1);
      @(posedge ref_clk_in);
      master_clear_pin_n_in <= 1'b1;
      axi_rd(CR, d, r);
      chk(d, 32'h00000080);
      axi_wr(CR, 32'h0000FFFF, 4'hF, r);
      @(posedge ref_clk_in);
      poweron_reset_in <= 1'b1;
      @(posedge ref_clk_in);
      poweron_reset_in <= 1'b0;
      axi_rd(CR, d, r);
      chk(d & 32'h0000C2D1, 32'h00000001);
      tally_and_finish();
   end
endmodule
